// [core/ffc_filter_fail_capture.sv]
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
// Overview of operation
// R1 - a failure or overlap exposes address bits N+32 down to 32 in the unit's upper field.
// R2 - the captured upper address holds until software clears the unit's interrupt status.
// R3 - capture happens even when the action setting drives no interrupt.
// R4 - while the unit's status flag is set, later failures leave all fail registers alone.
// R5 - the first failure after reset or after the last clear is the one captured.
// R6 - the control attributes of that first failure are kept beside its address.
// R7 - attribute bit 24 gives the direction, 0 read and 1 write.
// R8 - every filter unit has its own attribute register, indexed by unit number.
// R9 - writing one to a unit's clear bit drops its status, overrun and overlap flags.
// R10 - address bits 31 down to 0 of the first failure go to a per-unit low register.
// R11 - attribute bit 21 gives the security state, 0 secure and 1 non-secure.
module ffc_filter_fail_capture
  import ffc_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // checked accesses, one per filter unit
  input  wire ffc_access_type [NUM_UNITS-1:0] access,
  // register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DATA_W-1:0]     reg_rdata,
  // interrupt
  output logic                       irq
);

  ffc_state_type state_reg;
  ffc_state_type state_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // per-unit register hit: returns true when addr lands in unit u at sub
  function automatic logic unit_hit(input logic [REG_ADDR_W-1:0] a,
                                    input int unsigned u,
                                    input logic [3:0] sub);
    logic [REG_ADDR_W-1:0] base;
    base = OFS_UNIT_BASE + REG_ADDR_W'(u) * OFS_UNIT_STRIDE;
    return a == (base | {{(REG_ADDR_W-4){1'b0}}, sub});
  endfunction

  function automatic logic [DATA_W-1:0] attr_word(input ffc_record_type r);
    logic [DATA_W-1:0] w;
    w = ZERO_WORD;
    w[ATTR_DIR_BIT]  = r.write;       // R7
    w[ATTR_NS_BIT]   = r.non_secure;  // R11
    w[ATTR_PRIV_BIT] = r.privileged;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // clear is decoded before capture so that a new failure in the clear cycle
  // is recorded and raises status again; the event is never lost
  always_comb begin
    logic                 clr_wr;
    logic [NUM_UNITS-1:0] clr_bits;
    logic [DATA_W-1:0]    rd;
    logic                 ev;
    ffc_record_type       r;
    clr_wr     = 1'b0;
    clr_bits   = '0;
    rd         = ZERO_WORD;
    ev         = 1'b0;
    r          = '0;
    state_next = state_reg;
    clr_wr     = reg_wr && (reg_addr == OFS_INT_CLEAR);
    clr_bits   = clr_wr ? reg_wdata[NUM_UNITS-1:0] : '0;

    // register writes
    if (reg_wr && reg_addr == OFS_INT_MASK) begin
      state_next.irq_mask = reg_wdata[NUM_UNITS-1:0];
    end
    if (reg_wr && reg_addr == OFS_ACTION) begin
      state_next.action_irq = reg_wdata[NUM_UNITS-1:0];
    end
    // write-one clear rearms capture
    state_next.status  = state_reg.status  & ~clr_bits;  // R9
    state_next.overrun = state_reg.overrun & ~clr_bits;  // R9
    state_next.overlap = state_reg.overlap & ~clr_bits;  // R9

    // failure capture per unit, independent of action setting
    for (int u = 0; u < NUM_UNITS; u++) begin
      ev = access[u].fail || access[u].overlap;
      if (ev) begin
        if (!state_next.status[u]) begin  // R5
          r.addr_low   = access[u].addr[31:0];                        // R10
          r.addr_upper = access[u].addr[UPPER_ADDR_HI:UPPER_ADDR_LO]; // R1
          r.write      = access[u].write;       // R6
          r.non_secure = access[u].non_secure;  // R6
          r.privileged = access[u].privileged;
          state_next.rec[u]    = r;     // R3
          state_next.status[u] = 1'b1;
        end else begin
          state_next.overrun[u] = 1'b1;  // R4 R2
        end
        if (access[u].overlap) begin
          state_next.overlap[u] = 1'b1;
        end
      end
    end

    // read mux; status is not cleared by reads, only by the clear register
    if (reg_rd) begin
      if (reg_addr == OFS_INT_STATUS) begin
        rd[NUM_UNITS-1:0]                           = state_reg.status;
        rd[STAT_OVR_LSB +: NUM_UNITS]               = state_reg.overrun;
        rd[STAT_OVL_LSB +: NUM_UNITS]               = state_reg.overlap;
      end else if (reg_addr == OFS_INT_MASK) begin
        rd[NUM_UNITS-1:0] = state_reg.irq_mask;
      end else if (reg_addr == OFS_ACTION) begin
        rd[NUM_UNITS-1:0] = state_reg.action_irq;
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
        r = ffc_record_type'(state_reg.rec[u]);
        if (unit_hit(reg_addr, u, SUB_ADDR_LOW)) begin
          rd = r.addr_low;
        end else if (unit_hit(reg_addr, u, SUB_ADDR_UPPER)) begin
          rd[UPPER_FIELD_W-1:0] = r.addr_upper;  // R1
        end else if (unit_hit(reg_addr, u, SUB_ATTRIBUTES)) begin
          rd = attr_word(r);  // R8
        end
      end
    end
    state_next.rdata = rd;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // interrupt needs both the mask and the action setting
  assign irq       = |(state_reg.status & state_reg.irq_mask & state_reg.action_irq);
  assign reg_rdata = state_reg.rdata;

endmodule // ffc_filter_fail_capture

// [core/ffc_pkg.sv]
package ffc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_UNITS      = 4;   // filter units, 1 to 4
  localparam int unsigned UNIT_IDX_W     = 2;
  localparam int unsigned ADDR_W         = 64;  // system bus address width
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned REG_ADDR_W     = 12;
  localparam int unsigned UPPER_ADDR_HI  = 32 + NUM_UNITS;  // bit N+32
  localparam int unsigned UPPER_ADDR_LO  = 32;
  localparam int unsigned UPPER_FIELD_W  = UPPER_ADDR_HI - UPPER_ADDR_LO + 1;

  // ----------------------------------------------------------------
  // register map, one 0x10 block of four words per filter unit
  // ----------------------------------------------------------------
  localparam logic [REG_ADDR_W-1:0] OFS_INT_STATUS  = 12'h000;
  localparam logic [REG_ADDR_W-1:0] OFS_INT_CLEAR   = 12'h004;
  localparam logic [REG_ADDR_W-1:0] OFS_INT_MASK    = 12'h008;
  localparam logic [REG_ADDR_W-1:0] OFS_ACTION      = 12'h00c;
  localparam logic [REG_ADDR_W-1:0] OFS_UNIT_BASE   = 12'h100;
  localparam logic [REG_ADDR_W-1:0] OFS_UNIT_STRIDE = 12'h010;
  localparam logic [3:0]            SUB_ADDR_LOW    = 4'h0;
  localparam logic [3:0]            SUB_ADDR_UPPER  = 4'h4;
  localparam logic [3:0]            SUB_ATTRIBUTES  = 4'h8;

  // ----------------------------------------------------------------
  // fail attribute word layout
  // ----------------------------------------------------------------
  localparam int unsigned ATTR_DIR_BIT  = 24;  // 1 = write
  localparam int unsigned ATTR_NS_BIT   = 21;  // 1 = non-secure
  localparam int unsigned ATTR_PRIV_BIT = 20;  // 1 = privileged

  // interrupt status layout: status [N-1:0], overrun [N+7:8], overlap [N+15:16]
  localparam int unsigned STAT_OVR_LSB  = 8;
  localparam int unsigned STAT_OVL_LSB  = 16;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // one checked access per filter unit
  typedef struct packed {
    logic              fail;     // permission failure this cycle
    logic              overlap;  // region overlap this cycle
    logic              write;
    logic              non_secure;
    logic              privileged;
    logic [ADDR_W-1:0] addr;
  } ffc_access_type;

  // captured record of one unit
  typedef struct packed {
    logic [31:0]              addr_low;
    logic [UPPER_FIELD_W-1:0] addr_upper;
    logic                     write;
    logic                     non_secure;
    logic                     privileged;
  } ffc_record_type;

  typedef struct packed {
    logic [NUM_UNITS-1:0]                 status;
    logic [NUM_UNITS-1:0]                 overrun;
    logic [NUM_UNITS-1:0]                 overlap;
    logic [NUM_UNITS-1:0]                 irq_mask;
    logic [NUM_UNITS-1:0]                 action_irq;
    logic [NUM_UNITS-1:0][$bits(ffc_record_type)-1:0] rec;
    logic [DATA_W-1:0]                    rdata;
  } ffc_state_type;

endpackage

// [sim/ffc_filter_fail_capture_assertions.sv]
`timescale 1ns/100ps
module ffc_fail_checker
  import ffc_pkg::*;
(
  // clock and reset
  input wire logic                           mclk,
  input wire logic                           arst_n,
  // watched ports
  input wire ffc_access_type [NUM_UNITS-1:0] access,
  input wire logic [REG_ADDR_W-1:0]          reg_addr,
  input wire logic [DATA_W-1:0]              reg_wdata,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [DATA_W-1:0]              reg_rdata,
  input wire logic                           irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // clear with no event beside it, then the first failure
  sequence s_rearm(int u);
    reg_wr && reg_addr == OFS_INT_CLEAR && reg_wdata[u] && !access[u].fail && !access[u].overlap
    ##1 access[u].fail;
  endsequence
  sequence s_rd(logic [11:0] a);
    reg_rd && reg_addr == a;
  endsequence
  clear_reads_zero_a: assert property (s_rd(OFS_INT_CLEAR) |=> reg_rdata == ZERO_WORD)
    else $error("clear register read nonzero");
  status_set_a: assert property (access[1].fail ##1 s_rd(OFS_INT_STATUS) |=> reg_rdata[1])
    else $error("status not set by failure");
  status_clear_a: assert property (reg_wr && reg_addr == OFS_INT_CLEAR && reg_wdata[0]
    && !access[0].fail && !access[0].overlap ##1 reg_rd && reg_addr == OFS_INT_STATUS
    && !access[0].fail |=> reg_rdata[16] == 1'b0 && reg_rdata[8] == 1'b0 && !reg_rdata[0])
    else $error("flags survived clear");
  upper_rsvd_a: assert property (s_rd(12'h104) |=> reg_rdata[31:UPPER_FIELD_W] == '0)
    else $error("upper reserved bits set");
  attr_rsvd_a: assert property (s_rd(12'h108) |=> reg_rdata[31:25] == '0
    && reg_rdata[23:22] == '0 && reg_rdata[19:0] == '0) else $error("attr reserved bits set");
  upper_capture_a: assert property (s_rearm(0) ##1 s_rd(12'h104) |=>
    reg_rdata[UPPER_FIELD_W-1:0] == $past(access[0].addr[36:32], 2)) else $error("bad upper");
  low_hold_a: assert property (s_rearm(0) ##1 access[0].fail ##1 s_rd(12'h100) |=>
    reg_rdata == $past(access[0].addr[31:0], 3)) else $error("low address not held");
  attr_capture_a: assert property (s_rearm(1) ##1 s_rd(OFS_INT_STATUS) ##1 s_rd(12'h118)
    |=> reg_rdata[24] == $past(access[1].write, 3) && reg_rdata[21] == $past(access[1].non_secure, 3))
    else $error("bad attributes");
endmodule // ffc_fail_checker
bind ffc_filter_fail_capture ffc_fail_checker u_chk (.mclk(mclk), .arst_n(arst_n), .access(access),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq));

// [sim/ffc_master_model.sv]
`timescale 1ns/100ps
module ffc_master_model
  import ffc_pkg::*;
(
  // clock
  input wire logic                      mclk,
  // accesses into the filter units
  output ffc_access_type [NUM_UNITS-1:0] access
);
  ffc_access_type [NUM_UNITS-1:0] evq[$];
  ffc_access_type [NUM_UNITS-1:0] stage = '0;
  initial access = '0;
  // idle units carry scrambled attributes, so a stale record cannot pass
  always @(negedge mclk) begin
    stage = (evq.size() > 0) ? evq.pop_front() : '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (!stage[u].fail && !stage[u].overlap) stage[u] = {2'b00, 3'($urandom), $urandom, $urandom};
    end
  end
  always @(posedge mclk) access <= stage;
  // one event per call, one cycle each
  task automatic issue(input int u, input ffc_access_type ev);
    ffc_access_type [NUM_UNITS-1:0] v;
    v = '0;
    v[u] = ev;
    evq.push_back(v);
  endtask
endmodule // ffc_master_model

// [sim/ffc_filter_fail_capture_bench.sv]
`timescale 1ns/100ps
module ffc_filter_fail_capture_bench
  import ffc_pkg::*;
;
  logic mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0, irq;
  logic [11:0] reg_addr = '0, ub;
  logic [31:0] reg_wdata = '0, reg_rdata, expq[$];
  ffc_access_type [NUM_UNITS-1:0] access;
  ffc_access_type ev;
  int bad_count = 0, comparisons = 0, cycles = 0;
  ffc_filter_fail_capture DUT (.mclk(mclk), .arst_n(arst_n), .access(access), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  ffc_master_model master (.mclk(mclk), .access(access));
  initial forever #10 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    op(1'b0, 1'b1, a, '0);
  endtask
  // irq may be registered, so give it two quiet cycles
  task automatic irq_is(input logic e);
    repeat (2) op(1'b0, 1'b0, '0, '0);
    @(negedge mclk);
    check(32'(irq), 32'(e));
    @(posedge mclk);
  endtask
  function automatic ffc_access_type rnd_ev(input logic ovl);
    return {~ovl, ovl, 3'($urandom), $urandom, $urandom};
  endfunction
  function automatic logic [31:0] attr_of(input ffc_access_type e);
    return (32'(e.write) << 24) | (32'(e.non_secure) << 21) | (32'(e.privileged) << 20);
  endfunction
  // read data arrive a cycle late; compare against the oldest note
  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk) if (rd_seen) check(reg_rdata, expq.pop_front());
  always @(posedge mclk) if (++cycles == 2000) begin
    bad_count++;
    finish_test();
  end
  initial begin
    void'($urandom(73));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    op(1, 0, OFS_INT_MASK, 32'hf);
    // each unit: two failures in a row, only the first kept
    for (int u = 0; u < NUM_UNITS; u++) begin
      ub = OFS_UNIT_BASE + OFS_UNIT_STRIDE * 12'(u);
      ev = rnd_ev(0);
      master.issue(u, ev);
      master.issue(u, rnd_ev(0));
      repeat (3) op(0, 0, 0, 0);
      rd(ub, ev.addr[31:0]);
      rd(ub + 12'h4, 32'(ev.addr[36:32]));
      rd(ub + 12'h8, attr_of(ev));
    end
    rd(OFS_INT_STATUS, 32'h0f0f);
    op(1, 0, OFS_INT_CLEAR, 32'hf);
    rd(OFS_INT_STATUS, 32'h0);
    rd(OFS_INT_CLEAR, 32'h0);
    rd(12'hffc, 32'h0);
    $display("test capture done");
    // rearm unit 0, then a failure right after the clear
    ev = rnd_ev(0);
    master.issue(0, ev);
    op(1, 0, OFS_INT_CLEAR, 32'h1);
    // the failure lands one edge after the clear, so let it settle first
    op(0, 0, 0, 0);
    rd(12'h104, 32'(ev.addr[36:32]));
    ev = rnd_ev(0);
    master.issue(0, ev);
    master.issue(0, rnd_ev(0));
    op(1, 0, OFS_INT_CLEAR, 32'h1);
    repeat (2) op(0, 0, 0, 0);
    rd(12'h100, ev.addr[31:0]);
    ev = rnd_ev(0);
    master.issue(1, ev);
    op(1, 0, OFS_INT_CLEAR, 32'h2);
    op(0, 0, 0, 0);
    rd(OFS_INT_STATUS, 32'h0103);
    rd(12'h118, attr_of(ev));
    irq_is(0);
    $display("test rearm done");
    // overlap on unit 2, then raise, mask and clear the interrupt
    ev = rnd_ev(1);
    master.issue(2, ev);
    op(1, 0, OFS_ACTION, 32'hf);
    repeat (2) op(0, 0, 0, 0);
    rd(12'h124, 32'(ev.addr[36:32]));
    rd(OFS_INT_STATUS, 32'h0004_0107);
    irq_is(1);
    op(1, 0, OFS_INT_MASK, 32'h0);
    irq_is(0);
    op(1, 0, OFS_INT_MASK, 32'hf);
    irq_is(1);
    op(1, 0, OFS_INT_CLEAR, 32'hf);
    irq_is(0);
    $display("test interrupt done");
    finish_test();
  end
endmodule // ffc_filter_fail_capture_bench
